// File: include/fpbc_defs.svh
// constant definitions for the front panel breakpoint control block
`ifndef FPBC_DEFS_SVH
`define FPBC_DEFS_SVH

`define FPBC_CLOCK_HZ 250_000_000
`define FPBC_REPEAT_HZ 1_000
`define FPBC_REPEAT_CYCLES (`FPBC_CLOCK_HZ / `FPBC_REPEAT_HZ)

`define FPBC_SEL_CENTER 2'h0
`define FPBC_SEL_LOW 2'h1
`define FPBC_SEL_HIGH 2'h2

`define FPBC_NOP_OPCODE 8'h00
`define FPBC_WAITS_NONE 2'h0
`define FPBC_WAITS_ONE 2'h1
`define FPBC_WAITS_TWO 2'h2
`define FPBC_WAITS_THREE 2'h3

`endif

// File: include/fpbc_pkg.sv
// types shared by the front panel breakpoint control design
package fpbc_pkg;
    typedef enum logic [1:0] {
        RUNNING,
        STOP_PENDING,
        STOPPED
    } run_state_t;
endpackage

// File: logic/tick_divider.sv
// divider that produces a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/100ps
module tick_divider #(
    parameter int CYCLES = 250000
) (
    input wire logic clock,
    input wire logic rst_n,
    output logic tick
);
    localparam int W = $clog2(CYCLES);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic tick_d;
    logic tick_q;

    if (CYCLES < 2) begin : g_bad_cycles
        $error("tick_divider needs CYCLES of at least 2");
    end

    always_comb begin
        tick_d = 1'b0;
        count_d = count_q + W'(1);
        if (count_q == W'(CYCLES - 1)) begin
            count_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            tick_q <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    chk_tick_single: assert property (@(posedge clock) disable iff (!rst_n)
        tick |=> !tick)
        else $error("divider tick lasted more than one cycle");
endmodule

// File: logic/front_panel_breakpoint_control.sv
// run/stop and breakpoint control logic of the bus front panel
`timescale 1ns/100ps
`include "fpbc_defs.svh"
module front_panel_breakpoint_control import fpbc_pkg::*; #(
    parameter int REPEAT_CYCLES = `FPBC_REPEAT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run_stop_switch,
    input wire logic [1:0] fetch_cycle_qualifier,
    input wire logic [1:0] io_direction_qualifier,
    input wire logic [1:0] ack_qualifier,
    input wire logic one_wait_option,
    input wire logic two_wait_option,
    input wire logic three_wait_option,
    input wire logic status_stop_option,
    input wire logic bus_stable_qualify,
    input wire logic latched_stop_option,
    input wire logic addr_data_stop_option,
    input wire logic mismatch_stop_option,
    input wire logic breakpoint_source_select,
    input wire logic continuous_noop,
    input wire logic continuous_store,
    input wire logic repeat_function_option,
    input wire logic latch_clear_button,
    input wire logic external_qualifier,
    input wire logic fetch_status,
    input wire logic output_status,
    input wire logic input_status,
    input wire logic interrupt_ack_status,
    input wire logic hold_ack_status,
    input wire logic bus_stable,
    input wire logic data_input_strobe,
    input wire logic cycle_sync,
    input wire logic processor_clock,
    input wire logic external_stop_request,
    input wire logic [2:0] function_switch,
    input wire logic [7:0] data_bus,
    input wire logic [15:0] address_bus,
    input wire logic [15:0] address_switches,
    output logic wait_request_out,
    output logic breakpoint_trigger,
    output logic breakpoint_latched,
    output logic latch_indicator,
    output logic noop_indicator,
    output logic store_indicator,
    output logic repeat_indicator,
    output logic [7:0] forced_data,
    output logic forced_data_oe,
    output logic memory_write_pulse,
    output logic [2:0] function_strobe
);
    localparam int SYNC_W = 74;

    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_sync_n;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic run_sw, ww1, ww2, ww3, st_opt, bs_opt, lt_opt, ad_opt, mm_opt, src_data;
    logic cn_opt, cs_opt, rp_opt, lclr, ext_q, m1, sout, sinp, sinta, shlda;
    logic bstab, dbin, psync, pclk, ext_stop;
    logic [1:0] fq_sel, io_sel, ack_sel;
    logic [2:0] func;
    logic [7:0] dbus;
    logic [15:0] abus, asw;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    // every panel and bus input is asynchronous to this clock
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {run_stop_switch, fetch_cycle_qualifier, io_direction_qualifier,
                ack_qualifier, one_wait_option, two_wait_option, three_wait_option,
                status_stop_option, bus_stable_qualify, latched_stop_option,
                addr_data_stop_option, mismatch_stop_option, breakpoint_source_select,
                continuous_noop, continuous_store, repeat_function_option,
                latch_clear_button, external_qualifier, fetch_status, output_status,
                input_status, interrupt_ack_status, hold_ack_status, bus_stable,
                data_input_strobe, cycle_sync, processor_clock, external_stop_request,
                function_switch, data_bus, address_bus, address_switches};
            sync2_q <= sync1_q;
        end
    end
    assign {run_sw, fq_sel, io_sel, ack_sel, ww1, ww2, ww3, st_opt, bs_opt, lt_opt, ad_opt,
        mm_opt, src_data, cn_opt, cs_opt, rp_opt, lclr, ext_q, m1, sout, sinp, sinta, shlda,
        bstab, dbin, psync, pclk, ext_stop, func, dbus, abus, asw} = sync2_q;

    function automatic logic qual_ok(input logic [1:0] sel, input logic low_ok,
            input logic high_ok);
        qual_ok = (sel == `FPBC_SEL_CENTER) || (sel == `FPBC_SEL_LOW && low_ok) ||
            (sel == `FPBC_SEL_HIGH && high_ok);
    endfunction

    // qualifiers and comparators
    logic enable, data_match, addr_match, mismatch, selected_bp;
    always_comb begin
        enable = qual_ok(fq_sel, !m1, m1)
            && qual_ok(io_sel, sout, sinp)
            && qual_ok(ack_sel, sinta, shlda)
            && ext_q
            && (!bs_opt || bstab);
        data_match = enable && (dbus == asw[7:0]);
        addr_match = enable && (abus == asw);
        mismatch = enable && (dbus != asw[7:0]);
        selected_bp = src_data ? data_match : addr_match;
    end

    // edge history of the slow bus strobes and the function switches
    logic psync_q, pclk_q, bstab_q;
    logic [2:0] func_q;
    logic cycle_start, pclk_rise, bs_rise;
    assign cycle_start = psync && !psync_q;
    assign pclk_rise = pclk && !pclk_q;
    assign bs_rise = bstab && !bstab_q;

    // breakpoint latch and its next-cycle stop
    logic latch_d, latch_q, latch_cycle_d, latch_cycle_q;
    always_comb begin
        latch_d = latch_q;
        if (lclr) begin
            latch_d = 1'b0;
        end
        if (bs_rise && selected_bp) begin
            latch_d = 1'b1;
        end
        // the stop waits for the next cycle start, since the latch sets too late for this one
        latch_cycle_d = latch_cycle_q;
        if (!latch_q) begin
            latch_cycle_d = 1'b0;
        end else if (cycle_start) begin
            latch_cycle_d = 1'b1;
        end
    end

    // data breakpoint wait state generator
    logic [1:0] wait_cnt_d, wait_cnt_q, wait_sel;
    always_comb begin
        wait_sel = three_wait_sel(ww1, ww2, ww3);
        wait_cnt_d = wait_cnt_q;
        if (cycle_start && src_data && enable && !st_opt) begin
            wait_cnt_d = wait_sel;
        end else if (pclk_rise && wait_cnt_q != `FPBC_WAITS_NONE) begin
            wait_cnt_d = wait_cnt_q - `FPBC_WAITS_ONE;
        end
    end

    function automatic logic [1:0] three_wait_sel(input logic a, input logic b, input logic c);
        three_wait_sel = c ? `FPBC_WAITS_THREE : b ? `FPBC_WAITS_TWO :
            a ? `FPBC_WAITS_ONE : `FPBC_WAITS_NONE;
    endfunction

    // run/stop state
    run_state_t state_d, state_q;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RUNNING: begin
                if (!run_sw) begin
                    state_d = STOP_PENDING;
                end
            end
            STOP_PENDING: begin
                if (run_sw) begin
                    state_d = RUNNING;
                end else if (cycle_start && m1) begin
                    state_d = STOPPED;
                end
            end
            STOPPED: begin
                if (run_sw) begin
                    state_d = RUNNING;
                end
            end
        endcase
    end

    logic stop_request;
    always_comb begin
        stop_request = ext_stop || state_q == STOPPED
            || (st_opt && enable)
            || (ad_opt && selected_bp)
            || (mm_opt && mismatch)
            || (lt_opt && latch_cycle_q);
    end

    // continuous modes and repeated functions
    logic tick;
    logic trig_d, trig_q, wait_d, wait_q, fdoe_d, fdoe_q, mwr_d, mwr_q;
    logic [2:0] fstb_d, fstb_q;
    always_comb begin
        trig_d = selected_bp;
        wait_d = stop_request || wait_cnt_q != `FPBC_WAITS_NONE
            || cs_opt;
        fdoe_d = cn_opt && dbin;
        mwr_d = cs_opt && tick;
        // one strobe per actuation, or a fresh one every tick while held
        fstb_d = (func & ~func_q) | (rp_opt ? (func & {3{tick}}) : 3'h0);
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            psync_q <= 1'b0;
            pclk_q <= 1'b0;
            bstab_q <= 1'b0;
            func_q <= 3'h0;
            latch_q <= 1'b0;
            latch_cycle_q <= 1'b0;
            wait_cnt_q <= `FPBC_WAITS_NONE;
            state_q <= STOPPED;
            trig_q <= 1'b0;
            wait_q <= 1'b1;
            fdoe_q <= 1'b0;
            mwr_q <= 1'b0;
            fstb_q <= 3'h0;
        end else begin
            psync_q <= psync;
            pclk_q <= pclk;
            bstab_q <= bstab;
            func_q <= func;
            latch_q <= latch_d;
            latch_cycle_q <= latch_cycle_d;
            wait_cnt_q <= wait_cnt_d;
            state_q <= state_d;
            trig_q <= trig_d;
            wait_q <= wait_d;
            fdoe_q <= fdoe_d;
            mwr_q <= mwr_d;
            fstb_q <= fstb_d;
        end
    end

    tick_divider #(
        .CYCLES(REPEAT_CYCLES)
    ) u_repeat_tick (
        .clock(clock),
        .rst_n(rst_sync_n),
        .tick(tick)
    );

    assign wait_request_out = wait_q;
    assign breakpoint_trigger = trig_q;
    assign breakpoint_latched = latch_q;
    assign latch_indicator = latch_q;
    assign noop_indicator = cn_opt;
    assign store_indicator = cs_opt;
    assign repeat_indicator = rp_opt;
    assign forced_data = `FPBC_NOP_OPCODE;
    assign forced_data_oe = fdoe_q;
    assign memory_write_pulse = mwr_q;
    assign function_strobe = fstb_q;

    sequence fetch_start;
        cycle_start && m1;
    endsequence

    sequence stop_armed;
        state_q == STOP_PENDING && !run_sw;
    endsequence

    chk_fetch_stop: assert property (@(posedge clock) disable iff (!rst_sync_n)
        stop_armed and fetch_start |=> state_q == STOPPED ##1 wait_request_out)
        else $error("stop not taken at instruction fetch");

    chk_run_free: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !stop_request && wait_cnt_q == `FPBC_WAITS_NONE && !cs_opt
        |=> !wait_request_out)
        else $error("wait requested without a cause");

    chk_status_stop: assert property (@(posedge clock) disable iff (!rst_sync_n)
        st_opt && enable |=> wait_request_out)
        else $error("status stop did not hold the processor");

    chk_match_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !enable |=> !breakpoint_trigger)
        else $error("breakpoint trigger without enable");

    chk_ext_disable: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !ext_q |=> !breakpoint_trigger)
        else $error("external qualifier low did not block trigger");

    chk_latch_set: assert property (@(posedge clock) disable iff (!rst_sync_n)
        bs_rise && selected_bp |=> breakpoint_latched && latch_indicator)
        else $error("breakpoint latch failed to set");

    chk_latch_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
        latch_q && !lclr |=> latch_q [*1] ##0 $stable(breakpoint_latched))
        else $error("latch dropped without clear");

    chk_wait_three: assert property (@(posedge clock) disable iff (!rst_sync_n)
        cycle_start && src_data && enable && !st_opt && ww3
        |=> wait_cnt_q == `FPBC_WAITS_THREE ##1 wait_request_out)
        else $error("three wait states not loaded");

    chk_nop_forced: assert property (@(posedge clock) disable iff (!rst_sync_n)
        cn_opt && dbin |=> forced_data_oe && forced_data == `FPBC_NOP_OPCODE)
        else $error("no-op opcode not forced");

    chk_store_wait: assert property (@(posedge clock) disable iff (!rst_sync_n)
        cs_opt [*2] |-> wait_request_out)
        else $error("continuous store did not hold wait");

    chk_latched_next: assert property (@(posedge clock) disable iff (!rst_sync_n)
        lt_opt && latch_q && cycle_start ##1 lt_opt |=> wait_request_out)
        else $error("latched stop missed the next cycle");
endmodule

// File: bench/bus_processor_model.sv
// behavioural bus processor: eight-clock machine cycles, stalls in phase 5 while wait is asked
`timescale 1ns/100ps
module bus_processor_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wait_request_out,
    input wire logic [7:0] forced_data,
    input wire logic forced_data_oe,
    output logic cycle_sync,
    output logic processor_clock,
    output logic fetch_status,
    output logic bus_stable,
    output logic data_input_strobe,
    output logic [7:0] data_bus,
    output logic [15:0] address_bus
);
    logic [2:0] phase_q;
    logic [7:0] last_q;
    assign cycle_sync = (phase_q == 3'h0);
    assign bus_stable = (phase_q >= 3'h3) && (phase_q <= 3'h6);
    assign data_input_strobe = (phase_q >= 3'h2);
    // released bus shows the inverse of the last byte so a stale value never matches by luck
    assign data_bus = forced_data_oe ? forced_data :
        (data_input_strobe ? (address_bus[7:0] ^ 8'h5a) : ~last_q);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 3'h0;
            address_bus <= 16'h0000;
            fetch_status <= 1'b1;
            processor_clock <= 1'b0;
            last_q <= 8'h00;
        end else begin
            processor_clock <= ~processor_clock;
            if (data_input_strobe) begin
                last_q <= data_bus;
            end
            if (phase_q != 3'h5 || !wait_request_out) begin
                phase_q <= phase_q + 3'h1;
                if (phase_q == 3'h7) begin
                    address_bus <= address_bus + 16'h0001;
                    fetch_status <= ~fetch_status;
                end
            end
        end
    end
endmodule

// File: bench/front_panel_breakpoint_control_bench.sv
// self-checking bench: operator settings against the behavioural bus processor
`timescale 1ns/100ps
module front_panel_breakpoint_control_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic run_stop_switch, one_wait_option, two_wait_option, three_wait_option;
    logic status_stop_option, bus_stable_qualify, latched_stop_option, addr_data_stop_option;
    logic mismatch_stop_option, breakpoint_source_select, continuous_noop, continuous_store;
    logic repeat_function_option, latch_clear_button, external_qualifier, external_stop_request;
    logic [1:0] fetch_cycle_qualifier, io_direction_qualifier, ack_qualifier;
    logic [2:0] function_switch, function_strobe;
    logic [3:0] st;
    logic [15:0] address_switches, address_bus;
    logic cycle_sync, processor_clock, fetch_status, bus_stable, data_input_strobe;
    logic [7:0] data_bus, forced_data;
    logic wait_request_out, breakpoint_trigger, breakpoint_latched, latch_indicator;
    logic noop_indicator, store_indicator, repeat_indicator, forced_data_oe, memory_write_pulse;
    int n_fail = 0;
    int num_checks = 0;
    int cnt [4];
    int c;

    // short repeat period keeps the 1 kHz functions inside a brief run
    front_panel_breakpoint_control #(
        .REPEAT_CYCLES(16)
    ) u_front_panel_breakpoint_control (
        .clock(clock),
        .rst_n(rst_n),
        .run_stop_switch(run_stop_switch),
        .fetch_cycle_qualifier(fetch_cycle_qualifier),
        .io_direction_qualifier(io_direction_qualifier),
        .ack_qualifier(ack_qualifier),
        .one_wait_option(one_wait_option),
        .two_wait_option(two_wait_option),
        .three_wait_option(three_wait_option),
        .status_stop_option(status_stop_option),
        .bus_stable_qualify(bus_stable_qualify),
        .latched_stop_option(latched_stop_option),
        .addr_data_stop_option(addr_data_stop_option),
        .mismatch_stop_option(mismatch_stop_option),
        .breakpoint_source_select(breakpoint_source_select),
        .continuous_noop(continuous_noop),
        .continuous_store(continuous_store),
        .repeat_function_option(repeat_function_option),
        .latch_clear_button(latch_clear_button),
        .external_qualifier(external_qualifier),
        .fetch_status(fetch_status),
        .output_status(st[0]),
        .input_status(st[1]),
        .interrupt_ack_status(st[2]),
        .hold_ack_status(st[3]),
        .bus_stable(bus_stable),
        .data_input_strobe(data_input_strobe),
        .cycle_sync(cycle_sync),
        .processor_clock(processor_clock),
        .external_stop_request(external_stop_request),
        .function_switch(function_switch),
        .data_bus(data_bus),
        .address_bus(address_bus),
        .address_switches(address_switches),
        .wait_request_out(wait_request_out),
        .breakpoint_trigger(breakpoint_trigger),
        .breakpoint_latched(breakpoint_latched),
        .latch_indicator(latch_indicator),
        .noop_indicator(noop_indicator),
        .store_indicator(store_indicator),
        .repeat_indicator(repeat_indicator),
        .forced_data(forced_data),
        .forced_data_oe(forced_data_oe),
        .memory_write_pulse(memory_write_pulse),
        .function_strobe(function_strobe)
    );

    bus_processor_model u_bus_processor_model (
        .clock(clock),
        .rst_n(rst_n),
        .wait_request_out(wait_request_out),
        .forced_data(forced_data),
        .forced_data_oe(forced_data_oe),
        .cycle_sync(cycle_sync),
        .processor_clock(processor_clock),
        .fetch_status(fetch_status),
        .bus_stable(bus_stable),
        .data_input_strobe(data_input_strobe),
        .data_bus(data_bus),
        .address_bus(address_bus)
    );

    initial forever #2 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // wait bursts are short, so eight steady cycles mark a real stop or release
    task automatic await_wait(input logic exp);
        int run = 0;
        for (int i = 0; i < 300 && run < 8; i++) begin
            @(negedge clock);
            run = (wait_request_out === exp) ? run + 1 : 0;
        end
        chk(run >= 8, 1'b1);
    endtask

    task automatic quiet(input int n);
        int bad = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            bad += (wait_request_out !== 1'b0 || breakpoint_trigger !== 1'b0);
        end
        chk(bad == 0, 1'b1);
    endtask

    task automatic count(input int sel, input int n, output int total);
        total = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            total += (sel == 0) ? wait_request_out : (sel == 1) ? memory_write_pulse :
                (sel == 2) ? function_strobe[0] : breakpoint_trigger;
        end
    endtask

    task automatic open_all;
        {one_wait_option, two_wait_option, three_wait_option, status_stop_option,
         bus_stable_qualify, latched_stop_option, addr_data_stop_option,
         mismatch_stop_option, breakpoint_source_select, continuous_noop, continuous_store,
         repeat_function_option, latch_clear_button, external_stop_request} <= '0;
        {fetch_cycle_qualifier, io_direction_qualifier, ack_qualifier, function_switch, st} <= '0;
        {run_stop_switch, external_qualifier} <= 2'b11;
        address_switches <= 16'hffff;
    endtask

    initial begin
        #300000;
        n_fail++;
        stop_test();
    end

    initial begin
        open_all();
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        await_wait(1'b0);
        quiet(40);
        @(posedge clock) external_stop_request <= 1'b1;
        await_wait(1'b1);
        @(posedge clock) external_stop_request <= 1'b0;
        await_wait(1'b0);
        @(posedge clock) run_stop_switch <= 1'b0;
        await_wait(1'b1);
        chk(fetch_status, 1'b1);
        @(posedge clock) run_stop_switch <= 1'b1;
        await_wait(1'b0);
        @(posedge clock) begin
            addr_data_stop_option <= 1'b1;
            external_qualifier <= 1'b0;
            address_switches <= address_bus + 16'h0002;
        end
        quiet(60);
        @(posedge clock) begin
            external_qualifier <= 1'b1;
            address_switches <= address_bus + 16'h0002;
        end
        await_wait(1'b1);
        chk(address_bus, address_switches);
        chk(breakpoint_trigger, 1'b1);
        chk({breakpoint_latched, latch_indicator}, 2'b11);
        @(posedge clock) addr_data_stop_option <= 1'b0;
        await_wait(1'b0);
        @(posedge clock) latched_stop_option <= 1'b1;
        await_wait(1'b1);
        @(posedge clock) latch_clear_button <= 1'b1;
        repeat (4) @(posedge clock);
        latch_clear_button <= 1'b0;
        await_wait(1'b0);
        chk(breakpoint_latched, 1'b0);
        @(posedge clock) {latched_stop_option, status_stop_option} <= 2'b01;
        await_wait(1'b1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock) begin
                if (k < 2) io_direction_qualifier <= 2'(k + 1);
                else ack_qualifier <= 2'(k - 1);
            end
            await_wait(1'b0);
            quiet(40);
            @(posedge clock) st <= 4'h1 << k;
            await_wait(1'b1);
            @(posedge clock) {st, io_direction_qualifier, ack_qualifier} <= '0;
        end
        @(posedge clock) fetch_cycle_qualifier <= 2'h3;
        await_wait(1'b0);
        quiet(40);
        for (int f = 1; f < 3; f++) begin
            @(posedge clock) fetch_cycle_qualifier <= 2'(f);
            await_wait(1'b1);
            chk(fetch_status, f == 2);
            @(posedge clock) fetch_cycle_qualifier <= 2'h3;
            await_wait(1'b0);
        end
        @(posedge clock) open_all();
        @(posedge clock) {breakpoint_source_select, mismatch_stop_option} <= 2'b11;
        await_wait(1'b1);
        @(posedge clock) mismatch_stop_option <= 1'b0;
        await_wait(1'b0);
        for (int n = 0; n < 4; n++) begin
            // no wait option first, then one at a time, status stop open
            @(posedge clock) {three_wait_option, two_wait_option, one_wait_option} <=
                3'((4'h1 << n) >> 1);
            repeat (8) @(posedge clock);
            count(0, 96, cnt[n]);
            if (n > 0) chk(cnt[n] > cnt[n - 1], 1'b1);
        end
        chk(cnt[0] == 0, 1'b1);
        @(posedge clock) external_qualifier <= 1'b0;
        repeat (8) @(posedge clock);
        count(0, 96, c);
        chk(c == 0, 1'b1);
        @(posedge clock) open_all();
        // the match lasts one unstalled cycle, of which bus stable covers four clocks
        @(posedge clock) begin
            bus_stable_qualify <= 1'b1;
            address_switches <= address_bus + 16'h0002;
        end
        count(3, 64, c);
        chk(c, 4);
        @(posedge clock) bus_stable_qualify <= 1'b0;
        @(posedge clock) continuous_noop <= 1'b1;
        c = 0;
        for (int i = 0; i < 100 && c == 0; i++) begin
            @(negedge clock);
            c = forced_data_oe;
        end
        chk({c[0], data_bus, noop_indicator}, {1'b1, 8'h00, 1'b1});
        @(posedge clock) {continuous_noop, continuous_store} <= 2'b01;
        repeat (8) @(posedge clock);
        count(1, 80, c);
        chk({c >= 4 && c <= 6, wait_request_out, store_indicator}, 3'b111);
        @(posedge clock) {continuous_store, function_switch} <= 4'h1;
        count(2, 80, c);
        chk(c, 1);
        @(posedge clock) {function_switch, repeat_function_option} <= 4'h0;
        repeat (8) @(posedge clock);
        {function_switch, repeat_function_option} <= 4'h3;
        count(2, 80, c);
        chk({c >= 4, repeat_indicator}, 2'b11);
        stop_test();
    end
endmodule
